// [pkg/dcmpc_pkg.sv]
// dcmpc_pkg: register map, field positions, reset values and select codes
// of the dual comparator control block.
// assumes: used by the decode, top and assertion files through dcmpc_pkg::name.
package dcmpc_pkg;

	// ------------------------------------------------------------
	// register offsets
	// ------------------------------------------------------------
	localparam logic [11:0] CMP1_MAIN_CONTROL_OFS = 12'h80c;
	localparam logic [11:0] CMP1_EDGE_IRQ_CONFIG_OFS = 12'h80d;
	localparam logic [11:0] CMP1_INVERTING_SELECT_OFS = 12'h80e;
	localparam logic [11:0] CMP1_NONINVERTING_SELECT_OFS = 12'h80f;
	localparam logic [11:0] CMP2_MAIN_CONTROL_OFS = 12'h810;
	localparam logic [11:0] CMP2_EDGE_IRQ_CONFIG_OFS = 12'h811;
	localparam logic [11:0] CMP2_INVERTING_SELECT_OFS = 12'h812;
	localparam logic [11:0] CMP2_NONINVERTING_SELECT_OFS = 12'h813;
	localparam logic [11:0] IRQ_STATUS_OFS = 12'h81c;
	localparam logic [11:0] IRQ_MASK_OFS = 12'h81d;
	localparam logic [11:0] ALL_COMPARATOR_RESULTS_OFS = 12'h81f;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int ENABLE_BIT = 7;
	localparam int RESULT_BIT = 6;
	localparam int POLARITY_INVERT_BIT = 4;
	localparam int HYSTERESIS_ENABLE_BIT = 1;
	localparam int TIMER_SYNC_BIT = 0;
	localparam int RISE_IRQ_ENABLE_BIT = 1;
	localparam int FALL_IRQ_ENABLE_BIT = 0;
	localparam int SELECT_WIDTH = 3;

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [7:0] CONTROL_RESET = 8'h00;
	localparam logic [2:0] SELECT_RESET = 3'h0;
	localparam logic [1:0] FLAGS_RESET = 2'h0;

	// ------------------------------------------------------------
	// select codes
	// ------------------------------------------------------------
	localparam logic [2:0] SEL_PIN_ZERO = 3'h0;
	localparam logic [2:0] SEL_PIN_ONE = 3'h1;
	localparam logic [2:0] SEL_PIN_TWO = 3'h2;
	localparam logic [2:0] SEL_PIN_THREE = 3'h3;
	localparam logic [2:0] SEL_FIRST_DAC = 3'h4;
	localparam logic [2:0] SEL_FIXED_REF = 3'h6;
	localparam logic [2:0] SEL_GROUND = 3'h7;

	// one-hot analog switch vector: pins 0..3, dac, fixed ref, ground
	localparam int SOURCE_COUNT = 7;
	localparam int SRC_DAC = 4;
	localparam int SRC_FIXED_REF = 5;
	localparam int SRC_GROUND = 6;

endpackage

// [design/dcmpc_input_decode.sv]
// dcmpc_input_decode: turns the two input-select codes of one comparator
// into one-hot analog switch enables.
// assumes: select codes come from registers on the same clock.
`timescale 1ns/1ps
module dcmpc_input_decode (
	input wire logic enable, // comparator enable
	input wire logic [2:0] inverting_input_select, // inverting select code
	input wire logic [2:0] noninverting_input_select, // noninverting select code
	output logic [dcmpc_pkg::SOURCE_COUNT-1:0] inv_switch, // inverting switches
	output logic [dcmpc_pkg::SOURCE_COUNT-1:0] noninv_switch // noninverting switches
);

	// ------------------------------------------------------------
	// decode functions
	// ------------------------------------------------------------
	// inverting side: pins 0..3, fixed ref, ground; 100/101 open
	function automatic logic [dcmpc_pkg::SOURCE_COUNT-1:0] dcmpc_inv_dec(input logic [2:0] c);
		logic [dcmpc_pkg::SOURCE_COUNT-1:0] s;
		s = '0;
		if (c <= dcmpc_pkg::SEL_PIN_THREE) begin
			s[c] = 1'b1;
		end else if (c == dcmpc_pkg::SEL_FIXED_REF) begin
			s[dcmpc_pkg::SRC_FIXED_REF] = 1'b1;
		end else if (c == dcmpc_pkg::SEL_GROUND) begin
			s[dcmpc_pkg::SRC_GROUND] = 1'b1;
		end
		return s;
	endfunction

	// noninverting side: pins 0,1, dac, fixed ref, ground; rest open
	function automatic logic [dcmpc_pkg::SOURCE_COUNT-1:0] dcmpc_noninv_dec(input logic [2:0] c);
		logic [dcmpc_pkg::SOURCE_COUNT-1:0] s;
		s = '0;
		if (c <= dcmpc_pkg::SEL_PIN_ONE) begin
			s[c] = 1'b1;
		end else if (c == dcmpc_pkg::SEL_FIRST_DAC) begin
			s[dcmpc_pkg::SRC_DAC] = 1'b1;
		end else if (c == dcmpc_pkg::SEL_FIXED_REF) begin
			s[dcmpc_pkg::SRC_FIXED_REF] = 1'b1;
		end else if (c == dcmpc_pkg::SEL_GROUND) begin
			s[dcmpc_pkg::SRC_GROUND] = 1'b1;
		end
		return s;
	endfunction

	// disabled comparator has every switch open
	assign inv_switch = enable ? dcmpc_inv_dec(inverting_input_select) : '0;
	assign noninv_switch = enable ? dcmpc_noninv_dec(noninverting_input_select) : '0;

endmodule // dcmpc_input_decode

// [design/dcmpc_sync3.sv]
// dcmpc_sync3: three-flop synchroniser for one asynchronous level.
// assumes: the level may change at any time; out changes only once
// the second and third flops agree.
`timescale 1ns/1ps
module dcmpc_sync3 (
	input wire logic ref_clk, // system clock
	input wire logic rstn, // synchronous reset, active low
	input wire logic async_in, // asynchronous level
	output logic sync_out // filtered synchronous level
);

	logic s1_q;
	logic s2_q;
	logic s3_q;
	logic out_q;

	// ------------------------------------------------------------
	// capture chain; first flop feeds only the second
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
			s3_q <= 1'b0;
			out_q <= 1'b0;
		end else begin
			s1_q <= async_in;
			s2_q <= s1_q;
			s3_q <= s2_q;
			if (s2_q == s3_q) begin
				out_q <= s3_q;
			end
		end
	end

	assign sync_out = out_q;

endmodule // dcmpc_sync3

// [design/dcmpc_top.sv]
// dcmpc_top: control and status logic of two analog comparators.
// assumes: analog results and the companion timer clock arrive as
// asynchronous levels; software uses the plain register port.
//
// Summary of operation
// - a comparator is active only while its enable bit 7 is one.
// - bit 6 of the main control register reads the comparison result.
// - bit 4 set inverts the reported result, clear passes it through.
// - bit 1 drives the hysteresis enable toward the analog comparator.
// - with timer sync set the timer and pin output update on timer clock falls.
// - with timer sync clear the timer and pin output follow the result directly.
// - with rise enable set each low-to-high result edge sets the irq flag.
// - with fall enable set each high-to-low result edge sets the irq flag.
// - inverting select: pins 0-3, 110 fixed ref, 111 ground, 100/101 open.
// - noninverting select: pins 0,1, 100 dac, 110 ref, 111 ground, rest open.
// - the shared result register mirrors result 1 in bit 0 and result 2 in bit 1.
// - a disabled comparator gives its polarity bit as result and opens all its input switches.
// - a polarity change that toggles the result raises an edge irq even disabled.
// - the result is latched once per cycle; edges and reads use the latch.
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/1ps
module dcmpc_top #(
	parameter int NUM_CMP = 2 // comparators in the block
) (
	input wire logic ref_clk, // system clock, 40 MHz
	input wire logic rstn, // synchronous reset, active low
	input wire logic [11:0] reg_addr, // register address
	input wire logic [7:0] reg_wdata, // write data
	input wire logic reg_wr, // write strobe
	input wire logic reg_rd, // read strobe
	output logic [7:0] reg_rdata, // read data, cycle after the read strobe
	input wire logic [NUM_CMP-1:0] analog_result, // raw comparator outputs
	input wire logic timer_clk, // companion timer clock source
	output logic [NUM_CMP-1:0] cmp_output, // result to timer and pin
	output logic [NUM_CMP-1:0] cmp_enable, // analog enable
	output logic [NUM_CMP-1:0] hysteresis_enable, // analog hysteresis
	output logic [NUM_CMP*dcmpc_pkg::SOURCE_COUNT-1:0] inv_switch, // inverting switches
	output logic [NUM_CMP*dcmpc_pkg::SOURCE_COUNT-1:0] noninv_switch, // noninverting switches
	output logic irq // level interrupt
);

	// ------------------------------------------------------------
	// shared state
	// ------------------------------------------------------------
	logic [NUM_CMP-1:0] cmp_irq_flag_q;
	logic [NUM_CMP-1:0] irq_mask_q;
	logic [NUM_CMP-1:0] reported;
	logic [NUM_CMP-1:0] result_q;
	logic [NUM_CMP-1:0] edge_evt;
	logic [7:0] reg_rdata_q;
	logic [7:0] rd_mux;
	logic irq_q;
	logic tclk_s;
	logic tclk_prev_q;
	logic tclk_fall;

	// timer clock is asynchronous: filter it, then find falling edges
	dcmpc_sync3 u_tclk_sync (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.async_in(timer_clk),
		.sync_out(tclk_s)
	);

	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			tclk_prev_q <= 1'b0;
		end else begin
			tclk_prev_q <= tclk_s;
		end
	end

	assign tclk_fall = tclk_prev_q & ~tclk_s;

	// ------------------------------------------------------------
	// per-comparator control, result and edge logic
	// ------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < NUM_CMP; g++) begin : g_cmp
			localparam logic [11:0] BASE = dcmpc_pkg::CMP1_MAIN_CONTROL_OFS + 12'(4 * g);
			logic [7:0] main_q;
			logic [1:0] edge_cfg_q;
			logic [2:0] inv_sel_q;
			logic [2:0] noninv_sel_q;
			logic raw_s;
			logic rep_q;
			logic out_q;
			logic wr_main;
			logic wr_edge;
			logic wr_inv;
			logic wr_noninv;
			logic rep_d;
			logic rise;
			logic fall;
			logic [dcmpc_pkg::SOURCE_COUNT-1:0] inv_sw;
			logic [dcmpc_pkg::SOURCE_COUNT-1:0] noninv_sw;
			logic [dcmpc_pkg::SOURCE_COUNT-1:0] inv_sw_q;
			logic [dcmpc_pkg::SOURCE_COUNT-1:0] noninv_sw_q;

			// register write decode
			assign wr_main = reg_wr && (reg_addr == BASE);
			assign wr_edge = reg_wr && (reg_addr == BASE + 12'h001);
			assign wr_inv = reg_wr && (reg_addr == BASE + 12'h002);
			assign wr_noninv = reg_wr && (reg_addr == BASE + 12'h003);

			// software-writable control; result bit never stored
			always_ff @(posedge ref_clk) begin
				if (!rstn) begin
					main_q <= dcmpc_pkg::CONTROL_RESET;
					edge_cfg_q <= dcmpc_pkg::FLAGS_RESET;
					inv_sel_q <= dcmpc_pkg::SELECT_RESET;
					noninv_sel_q <= dcmpc_pkg::SELECT_RESET;
				end else begin
					if (wr_main) begin
						main_q <= reg_wdata & 8'h93;
					end
					if (wr_edge) begin
						edge_cfg_q <= reg_wdata[1:0];
					end
					if (wr_inv) begin
						inv_sel_q <= reg_wdata[2:0];
					end
					if (wr_noninv) begin
						noninv_sel_q <= reg_wdata[2:0];
					end
				end
			end

			dcmpc_sync3 u_res_sync (
				.ref_clk(ref_clk),
				.rstn(rstn),
				.async_in(analog_result[g]),
				.sync_out(raw_s)
			);

			// disabled forces zero before polarity, so polarity still toggles
			assign rep_d = (main_q[dcmpc_pkg::ENABLE_BIT] & raw_s)
				^ main_q[dcmpc_pkg::POLARITY_INVERT_BIT];
			assign rise = ~rep_q & rep_d;
			assign fall = rep_q & ~rep_d;
			assign edge_evt[g] = (rise & edge_cfg_q[dcmpc_pkg::RISE_IRQ_ENABLE_BIT])
				| (fall & edge_cfg_q[dcmpc_pkg::FALL_IRQ_ENABLE_BIT]);

			// latched result each cycle; timer/pin copy per sync mode
			always_ff @(posedge ref_clk) begin
				if (!rstn) begin
					rep_q <= 1'b0;
					out_q <= 1'b0;
				end else begin
					rep_q <= rep_d;
					if (!main_q[dcmpc_pkg::TIMER_SYNC_BIT] || tclk_fall) begin
						out_q <= rep_d;
					end
				end
			end

			dcmpc_input_decode u_dec (
				.enable(main_q[dcmpc_pkg::ENABLE_BIT]),
				.inverting_input_select(inv_sel_q),
				.noninverting_input_select(noninv_sel_q),
				.inv_switch(inv_sw),
				.noninv_switch(noninv_sw)
			);

			// switch enables registered so outputs come from flops
			always_ff @(posedge ref_clk) begin
				if (!rstn) begin
					inv_sw_q <= '0;
					noninv_sw_q <= '0;
				end else begin
					inv_sw_q <= inv_sw;
					noninv_sw_q <= noninv_sw;
				end
			end

			assign reported[g] = rep_q;
			assign result_q[g] = out_q;
			assign cmp_enable[g] = main_q[dcmpc_pkg::ENABLE_BIT];
			assign hysteresis_enable[g] = main_q[dcmpc_pkg::HYSTERESIS_ENABLE_BIT];
			assign inv_switch[g*dcmpc_pkg::SOURCE_COUNT +: dcmpc_pkg::SOURCE_COUNT] = inv_sw_q;
			assign noninv_switch[g*dcmpc_pkg::SOURCE_COUNT +: dcmpc_pkg::SOURCE_COUNT] =
				noninv_sw_q;
		end
	endgenerate

	assign cmp_output = result_q;

	// ------------------------------------------------------------
	// interrupt status and mask
	// ------------------------------------------------------------
	logic wr_status;
	logic wr_mask;
	logic [NUM_CMP-1:0] flag_d;
	logic [NUM_CMP-1:0] mask_d;
	assign wr_status = reg_wr && (reg_addr == dcmpc_pkg::IRQ_STATUS_OFS);
	assign wr_mask = reg_wr && (reg_addr == dcmpc_pkg::IRQ_MASK_OFS);

	// write one clears; a same-cycle edge wins over the clear
	assign flag_d = (cmp_irq_flag_q & ~(wr_status ? reg_wdata[NUM_CMP-1:0] : '0))
		| edge_evt;
	assign mask_d = wr_mask ? reg_wdata[NUM_CMP-1:0] : irq_mask_q;

	// irq built from next values so it drops in the same cycle as the flag
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			cmp_irq_flag_q <= '0;
			irq_mask_q <= '0;
			irq_q <= 1'b0;
		end else begin
			cmp_irq_flag_q <= flag_d;
			irq_mask_q <= mask_d;
			irq_q <= |(flag_d & mask_d);
		end
	end

	assign irq = irq_q;

	// ------------------------------------------------------------
	// read mux
	// ------------------------------------------------------------
	function automatic logic [7:0] dcmpc_pad(input logic [NUM_CMP-1:0] v);
		logic [7:0] r;
		r = '0;
		r[NUM_CMP-1:0] = v;
		return r;
	endfunction

	always_comb begin
		rd_mux = 8'h00;
		if (reg_addr == dcmpc_pkg::ALL_COMPARATOR_RESULTS_OFS) begin
			rd_mux = dcmpc_pad(reported);
		end else if (reg_addr == dcmpc_pkg::IRQ_STATUS_OFS) begin
			rd_mux = dcmpc_pad(cmp_irq_flag_q);
		end else if (reg_addr == dcmpc_pkg::IRQ_MASK_OFS) begin
			rd_mux = dcmpc_pad(irq_mask_q);
		end else begin
			for (int i = 0; i < NUM_CMP; i++) begin
				if (reg_addr == dcmpc_pkg::CMP1_MAIN_CONTROL_OFS + 12'(4 * i)) begin
					rd_mux = g_main_rd(i);
				end else if (reg_addr == dcmpc_pkg::CMP1_EDGE_IRQ_CONFIG_OFS + 12'(4 * i)) begin
					rd_mux = g_edge_rd(i);
				end else if (reg_addr == dcmpc_pkg::CMP1_INVERTING_SELECT_OFS + 12'(4 * i)) begin
					rd_mux = g_inv_rd(i);
				end else if (reg_addr ==
					dcmpc_pkg::CMP1_NONINVERTING_SELECT_OFS + 12'(4 * i)) begin
					rd_mux = g_noninv_rd(i);
				end
			end
		end
	end

	// flattened register views for the read mux
	logic [NUM_CMP*8-1:0] main_flat;
	logic [NUM_CMP*8-1:0] edge_flat;
	logic [NUM_CMP*8-1:0] inv_flat;
	logic [NUM_CMP*8-1:0] noninv_flat;
	generate
		for (g = 0; g < NUM_CMP; g++) begin : g_flat
			assign main_flat[g*8 +: 8] = (g_cmp[g].main_q & 8'h93)
				| ({7'h00, g_cmp[g].rep_q} << dcmpc_pkg::RESULT_BIT);
			assign edge_flat[g*8 +: 8] = {6'h00, g_cmp[g].edge_cfg_q};
			assign inv_flat[g*8 +: 8] = {5'h00, g_cmp[g].inv_sel_q};
			assign noninv_flat[g*8 +: 8] = {5'h00, g_cmp[g].noninv_sel_q};
		end
	endgenerate

	function automatic logic [7:0] g_main_rd(input int i);
		return main_flat[i*8 +: 8];
	endfunction

	function automatic logic [7:0] g_edge_rd(input int i);
		return edge_flat[i*8 +: 8];
	endfunction

	function automatic logic [7:0] g_inv_rd(input int i);
		return inv_flat[i*8 +: 8];
	endfunction

	function automatic logic [7:0] g_noninv_rd(input int i);
		return noninv_flat[i*8 +: 8];
	endfunction

	// read data valid only in the cycle after the strobe
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			reg_rdata_q <= 8'h00;
		end else begin
			reg_rdata_q <= reg_rd ? rd_mux : 8'h00;
		end
	end

	assign reg_rdata = reg_rdata_q;

endmodule // dcmpc_top

// [test/dcmpc_sva.sv]
// dcmpc_sva: port-level assertions of the dual comparator control block.
// assumes: bound to dcmpc_top; one clock, synchronous active-low reset.
`timescale 1ns/1ps
module dcmpc_sva #(
	parameter int NUM_CMP = 2 // comparators in the block
) (
	input wire logic ref_clk, // system clock
	input wire logic rstn, // reset, active low
	input wire logic [11:0] reg_addr, // register address
	input wire logic [7:0] reg_wdata, // write data
	input wire logic reg_wr, // write strobe
	input wire logic reg_rd, // read strobe
	input wire logic [7:0] reg_rdata, // read data
	input wire logic [NUM_CMP-1:0] analog_result, // raw results
	input wire logic timer_clk, // timer clock
	input wire logic [NUM_CMP-1:0] cmp_output, // timer and pin result
	input wire logic [NUM_CMP-1:0] cmp_enable, // analog enable
	input wire logic [NUM_CMP-1:0] hysteresis_enable, // analog hysteresis
	input wire logic [NUM_CMP*dcmpc_pkg::SOURCE_COUNT-1:0] inv_switch, // inverting switches
	input wire logic [NUM_CMP*dcmpc_pkg::SOURCE_COUNT-1:0] noninv_switch, // noninverting
	input wire logic irq // level interrupt
);
	// ----
	// helper: timer sync of comparator 1 as written by software
	// ----
	logic sync_q;
	logic sync_d;
	assign sync_d = (reg_wr && reg_addr == 12'h80c) ? reg_wdata[0] : sync_q;
	// track the register one cycle after the write, like the design
	always_ff @(posedge ref_clk) begin
		if (!rstn)
			sync_q <= 1'b0;
		else
			sync_q <= sync_d;
	end

	default clocking dc @(posedge ref_clk); endclocking
	default disable iff (!rstn);

	a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
		else $error("read data not zero outside a read");
	a_enable_write: assert property ((reg_wr && reg_addr == 12'h80c)
		|=> cmp_enable[0] == $past(reg_wdata[7]))
		else $error("enable does not follow control write");
	a_hys_write: assert property ((reg_wr && reg_addr == 12'h810)
		|=> hysteresis_enable[1] == $past(reg_wdata[1]))
		else $error("hysteresis does not follow control write");
	a_off_switch: assert property (!cmp_enable[0] |=> inv_switch[6:0] == 7'h00
		&& noninv_switch[6:0] == 7'h00)
		else $error("switch closed while disabled");
	a_inv_ground: assert property ((reg_wr && reg_addr == 12'h80e && reg_wdata[2:0] == 3'h7)
		##1 cmp_enable[0] |=> inv_switch[6:0] == 7'h40)
		else $error("ground not selected on inverting input");
	a_noninv_dac: assert property ((reg_wr && reg_addr == 12'h80f && reg_wdata[2:0] == 3'h4)
		##1 cmp_enable[0] |=> noninv_switch[6:0] == 7'h10)
		else $error("dac not selected on noninverting input");
	a_mask_irq: assert property ((reg_wr && reg_addr == 12'h81d && reg_wdata[1:0] == 2'h0)
		|=> ##1 !irq)
		else $error("interrupt high with mask cleared");
	a_mirror_zero: assert property ((reg_rd && reg_addr == 12'h81f)
		|=> reg_rdata[7:2] == 6'h00)
		else $error("unused mirror bits not zero");
	a_ctrl_zero: assert property ((reg_rd && reg_addr == 12'h80c)
		|=> reg_rdata[5] == 1'b0 && reg_rdata[3:2] == 2'h0)
		else $error("unused control bits not zero");
	a_sync_hold: assert property ((sync_q && timer_clk) [*8] |=> $stable(cmp_output[0]))
		else $error("synced output moved without timer fall");

	c_mirror_read: cover property (reg_rd && reg_addr == 12'h81f);
	c_irq_rise: cover property ($rose(irq));
	c_sync_fall: cover property (sync_q && $fell(timer_clk));
endmodule // dcmpc_sva

// [test/dcmpc_tb_top.sv]
// dcmpc_tb_top: self-checking bench of the dual comparator control block.
// assumes: bench drives all ports; reads scored through an expectation queue.
`timescale 1ns/1ps
module dcmpc_tb_top;
	logic ref_clk = 1'b0;
	logic rstn = 1'b0;
	logic [11:0] reg_addr = 12'h000;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_rdata;
	logic [1:0] analog_result = 2'h0;
	logic timer_clk = 1'b1;
	logic [1:0] cmp_output;
	logic [1:0] cmp_enable;
	logic [1:0] hysteresis_enable;
	logic [13:0] inv_switch;
	logic [13:0] noninv_switch;
	logic irq;
	logic rd_seen = 1'b0;
	logic [7:0] exp_q[$];
	int n_mismatch = 0;
	int compares = 0;
	int seed = 65;

	dcmpc_top i_dcmpc_top (.ref_clk(ref_clk), .rstn(rstn), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.analog_result(analog_result), .timer_clk(timer_clk), .cmp_output(cmp_output),
		.cmp_enable(cmp_enable), .hysteresis_enable(hysteresis_enable),
		.inv_switch(inv_switch), .noninv_switch(noninv_switch), .irq(irq));

	// 40 MHz clock
	always #12.5 ref_clk = ~ref_clk;

	task check(input string what, input logic [13:0] seen, input logic [13:0] exp);
		compares++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask

	task stop_test;
		if (n_mismatch == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task wr(input logic [11:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask

	task rd(input logic [11:0] a, input logic [7:0] e);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		exp_q.push_back(e);
		@(posedge ref_clk);
		reg_rd <= 1'b0;
	endtask

	// change one raw result and wait for the output, bounded
	task drive(input int g, input logic v);
		int i;
		@(posedge ref_clk);
		analog_result[g] <= v;
		for (i = 0; i < 20 && cmp_output[g] !== v; i++)
			@(negedge ref_clk);
		check("timer output", 14'(cmp_output[g]), 14'(v));
		repeat (2) @(negedge ref_clk);
	endtask

	function automatic logic [6:0] sel_exp(input logic [2:0] c, input logic pos);
		if (c <= 3'h3 && !(pos && c > 3'h1))
			return 7'h01 << c;
		if (c == 3'h4)
			return pos ? 7'h10 : 7'h00;
		if (c >= 3'h6)
			return c == 3'h6 ? 7'h20 : 7'h40;
		return 7'h00;
	endfunction

	// read data stands in the cycle after the strobe
	always @(posedge ref_clk) begin
		if (rd_seen)
			check("read data", {6'h00, reg_rdata}, {6'h00, exp_q.pop_front()});
		rd_seen <= reg_rd;
	end

	// ----
	// main sequence
	// ----
	initial begin
		logic [11:0] b;
		logic [7:0] r;
		logic [7:0] m;
		int g;
		int j;
		repeat (4) @(posedge ref_clk);
		rstn <= 1'b1;
		for (b = 12'h80c; b <= 12'h81f; b++)
			rd(b, 8'h00);
		for (g = 0; g < 2; g++) begin
			b = 12'h80c + 12'(4 * g);
			m = 8'h01 << g;
			repeat (4) begin
				r = 8'($random(seed));
				wr(b, r);
				repeat (8) @(negedge ref_clk);
				check("enable", 14'(cmp_enable[g]), 14'(r[7]));
				check("hysteresis", 14'(hysteresis_enable[g]), 14'(r[1]));
				rd(b, (r & 8'h93) | {1'b0, r[4], 6'h00});
				for (j = 1; j < 4; j++) begin
					r = 8'($random(seed));
					wr(b + 12'(j), r);
					rd(b + 12'(j), r & (j == 1 ? 8'h03 : 8'h07));
				end
			end
			wr(b, 8'h80);
			for (j = 0; j < 8; j++) begin
				wr(b + 12'h002, 8'(j));
				wr(b + 12'h003, 8'(j));
				repeat (2) @(negedge ref_clk);
				check("inv switch", 14'(inv_switch[g*7+:7]), 14'(sel_exp(3'(j), 1'b0)));
				check("noninv switch", 14'(noninv_switch[g*7+:7]), 14'(sel_exp(3'(j), 1'b1)));
			end
			wr(b, 8'h00);
			repeat (2) @(negedge ref_clk);
			check("switches off", {inv_switch[g*7+:7], noninv_switch[g*7+:7]}, 14'h0);
			wr(12'h81f, 8'hff);
			wr(12'h81c, 8'h03);
			wr(12'h81d, 8'h03);
			rd(12'h81f, 8'h00);
			wr(b, 8'h80);
			wr(b + 12'h001, 8'h02);
			drive(g, 1'b1);
			check("irq rise", 14'(irq), 14'h1);
			rd(12'h81f, m);
			rd(b, 8'hc0);
			wr(12'h81c, m);
			drive(g, 1'b0);
			check("irq fall ignored", 14'(irq), 14'h0);
			wr(b + 12'h001, 8'h01);
			drive(g, 1'b1);
			check("irq rise ignored", 14'(irq), 14'h0);
			drive(g, 1'b0);
			check("irq fall", 14'(irq), 14'h1);
			rd(12'h81c, m);
			wr(b, 8'h00);
			wr(b + 12'h001, 8'h03);
			wr(12'h81c, 8'h03);
			wr(b, 8'h10);
			repeat (8) @(negedge ref_clk);
			rd(12'h81c, m);
			rd(b, 8'h50);
			wr(12'h81d, 8'h00);
			wr(b, 8'h00);
			repeat (8) @(negedge ref_clk);
			check("irq masked", 14'(irq), 14'h0);
			rd(12'h81c, m);
			wr(12'h81c, 8'h03);
		end
		// ----
		// timer synchronised output
		// ----
		wr(12'h80c, 8'h81);
		@(posedge ref_clk);
		analog_result[0] <= 1'b1;
		repeat (20) @(negedge ref_clk);
		check("synced output held", 14'(cmp_output[0]), 14'h0);
		rd(12'h81f, 8'h01);
		@(posedge ref_clk);
		timer_clk <= 1'b0;
		drive(0, 1'b1);
		@(posedge ref_clk);
		analog_result[0] <= 1'b0;
		repeat (20) @(negedge ref_clk);
		check("synced output held low clock", 14'(cmp_output[0]), 14'h1);
		@(posedge ref_clk);
		timer_clk <= 1'b1;
		repeat (10) @(negedge ref_clk);
		check("synced output held timer rise", 14'(cmp_output[0]), 14'h1);
		@(posedge ref_clk);
		timer_clk <= 1'b0;
		drive(0, 1'b0);
		stop_test;
	end

	// watchdog well beyond the expected run
	initial begin
		#500000;
		n_mismatch++;
		stop_test;
	end
endmodule // dcmpc_tb_top

bind dcmpc_top dcmpc_sva #(.NUM_CMP(NUM_CMP)) i_dcmpc_sva (.ref_clk(ref_clk), .rstn(rstn),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .analog_result(analog_result), .timer_clk(timer_clk),
	.cmp_output(cmp_output), .cmp_enable(cmp_enable), .hysteresis_enable(hysteresis_enable),
	.inv_switch(inv_switch), .noninv_switch(noninv_switch), .irq(irq));
